/* File: inc/pcm_consts.vh */
// constants for the power management control and monitor register bank
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH
`define PCM_A_LOCK    8'h42
`define PCM_A_VRCTL   8'h44
`define PCM_A_MASK    8'h43
`define PCM_A_RST     8'h48
`define PCM_A_FORCED_EMERGENCY_RESET    8'h49
`define PCM_A_VLIM    8'h51
`define PCM_A_ADP     8'h69
`define PCM_A_LBAT    8'h6A
`define PCM_A_STAT    8'h6F
`define PCM_A_WAKE    8'hD0
`define PCM_A_CMPA    8'hDD
`define PCM_A_CMPB    8'hDE
`define PCM_A_CMPC    8'hDF
`define PCM_R_LOCK    8'h00
`define PCM_R_VRCTL   8'h00
`define PCM_R_MASK    8'h00
`define PCM_R_RST     8'h1C
`define PCM_R_FORCED_EMERGENCY_RESET    8'h00
`define PCM_R_VLIM    8'h05
`define PCM_R_ADP     8'h0F
`define PCM_R_LBAT    8'hF8
`define PCM_R_WAKE    8'h00
`define PCM_R_CMP     8'h00
`define PCM_R_CMPC    8'h00
`define PCM_M_LOCK    8'h01
`define PCM_M_RST     8'h1F
`define PCM_B_LOCK    0
`define PCM_B_FORCED_EMERGENCY_RESET    0
`define PCM_B_VLCMP   6
`define PCM_B_BAT2EN  5
`define PCM_B_BAT1EN  4
`define PCM_B_ACEN    3
`define PCM_B_WAKE    0
`define PCM_B_CMODE   7
`define PCM_TICK_PS   30500
`define PCM_CLK_PS    4000
`define PCM_TICK_CYC  ((`PCM_TICK_PS + `PCM_CLK_PS - 1) / `PCM_CLK_PS)
`define PCM_US10_CYC  12'h9C4
`define PCM_ADP_81US  10'h003
`define PCM_ADP_10MS  10'h148
`define PCM_ADP_20MS  10'h290
`define PCM_ADP_30MS  10'h3D8
`define PCM_RST_20MS  13'h0290
`define PCM_RST_40MS  13'h0520
`define PCM_RST_80MS  13'h0A3F
`define PCM_RST_200MS 13'h199E
`define PCM_WAKE_HALF 15'h4009
`endif

/* File: hw/pcm_regs.v */
// register bank, debouncers, reset pulse and wake clock of the power manager
`timescale 1ns/100ps
`default_nettype none
`include "pcm_consts.vh"
module pcm_regs #(
  parameter TICK_CYC = `PCM_TICK_CYC
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output wire       reg_ack,
  input  wire [7:0] vr_en_pin,
  output wire [7:0] vr_enable,
  input  wire       input_sense_low,
  input  wire       adapter_in,
  input  wire       batt1_low_in,
  input  wire       batt2_low_in,
  input  wire       voltage_trip,
  output reg        input_low_det,
  output reg        reset_n_out,
  output reg        emergency_reset,
  output reg        wake_clk,
  output wire [2:0] reset_trip_level,
  output wire [3:0] input_low_threshold,
  output wire       input_low_comparator_enable,
  output wire       adapter_comparator_enable,
  output wire       battery_one_detect_enable,
  output wire       battery_two_detect_enable,
  output wire [7:0] comparator_a_reference,
  output wire [7:0] comparator_b_reference,
  output wire [7:0] comparator_c_reference
);
  reg [7:0]  lock_r, vrctl_r, mask_r, rst_r, vlim_r, adp_r, lbat_r, wake_r;
  reg [7:0]  cmpa_r, cmpb_r, cmpc_r;
  reg [12:0] tick_cnt_r;
  reg        tick_r;
  reg        adp_stat_r, adp_raw_r;
  reg [9:0]  adp_cnt_r;
  reg        b1_stat_r, b2_stat_r;
  reg [7:0]  b1_cnt_r, b2_cnt_r;
  reg [11:0] il_cnt_r;
  reg [12:0] rst_cnt_r;
  reg [14:0] wake_cnt_r;
  reg        trip_d_r;
  reg [9:0]  adp_lim;
  reg [7:0]  bat_lim;
  reg [12:0] rst_lim;
  reg [11:0] il_lim;
  wire       wr_lock = reg_wr & (reg_addr == `PCM_A_LOCK);

  // every access completes in its cycle, locked writes included
  assign reg_ack = reg_wr | reg_rd;

  // per-rail source select between enable pin and register enable
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_rail
      assign vr_enable[g] = mask_r[g] ? vrctl_r[g] : vr_en_pin[g];
    end
  endgenerate

  assign reset_trip_level            = rst_r[2:0];
  assign input_low_threshold         = vlim_r[3:0];
  assign input_low_comparator_enable = vlim_r[`PCM_B_VLCMP];
  assign adapter_comparator_enable   = lbat_r[`PCM_B_ACEN];
  assign battery_one_detect_enable   = lbat_r[`PCM_B_BAT1EN];
  assign battery_two_detect_enable   = lbat_r[`PCM_B_BAT2EN];
  assign comparator_a_reference      = cmpa_r;
  assign comparator_b_reference      = cmpb_r;
  assign comparator_c_reference      = cmpc_r;

  // register writes; locked regulator control simply keeps its value
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_r  <= `PCM_R_LOCK;
      vrctl_r <= `PCM_R_VRCTL;
      mask_r  <= `PCM_R_MASK;
      rst_r   <= `PCM_R_RST;
      vlim_r  <= `PCM_R_VLIM;
      adp_r   <= `PCM_R_ADP;
      lbat_r  <= `PCM_R_LBAT;
      wake_r  <= `PCM_R_WAKE;
      cmpa_r  <= `PCM_R_CMP;
      cmpb_r  <= `PCM_R_CMP;
      cmpc_r  <= `PCM_R_CMPC;
    end else if (reg_wr) begin
      if (wr_lock) begin
        lock_r <= reg_wdata & `PCM_M_LOCK;
      end else if (reg_addr == `PCM_A_VRCTL) begin
        if (!lock_r[`PCM_B_LOCK]) begin
          vrctl_r <= reg_wdata;
        end
      end else if (reg_addr == `PCM_A_MASK) begin
        mask_r <= reg_wdata;
      end else if (reg_addr == `PCM_A_RST) begin
        rst_r <= reg_wdata & `PCM_M_RST;
      end else if (reg_addr == `PCM_A_VLIM) begin
        vlim_r <= reg_wdata;
      end else if (reg_addr == `PCM_A_ADP) begin
        adp_r <= reg_wdata;
      end else if (reg_addr == `PCM_A_LBAT) begin
        lbat_r <= reg_wdata;
      end else if (reg_addr == `PCM_A_WAKE) begin
        wake_r <= reg_wdata;
      end else if (reg_addr == `PCM_A_CMPA) begin
        cmpa_r <= reg_wdata;
      end else if (reg_addr == `PCM_A_CMPB) begin
        cmpb_r <= reg_wdata;
      end else if (reg_addr == `PCM_A_CMPC) begin
        cmpc_r <= reg_wdata;
      end
    end
  end

  // read mux; unmapped addresses return zero
  always @* begin
    reg_rdata = 8'h00;
    if (reg_addr == `PCM_A_LOCK) begin
      reg_rdata = lock_r;
    end else if (reg_addr == `PCM_A_VRCTL) begin
      reg_rdata = vrctl_r;
    end else if (reg_addr == `PCM_A_MASK) begin
      reg_rdata = mask_r;
    end else if (reg_addr == `PCM_A_RST) begin
      reg_rdata = rst_r;
    end else if (reg_addr == `PCM_A_FORCED_EMERGENCY_RESET) begin
      reg_rdata = 8'h00;
    end else if (reg_addr == `PCM_A_VLIM) begin
      reg_rdata = vlim_r;
    end else if (reg_addr == `PCM_A_ADP) begin
      reg_rdata = adp_r;
    end else if (reg_addr == `PCM_A_LBAT) begin
      reg_rdata = lbat_r;
    end else if (reg_addr == `PCM_A_STAT) begin
      reg_rdata = {1'b0, b2_stat_r, b1_stat_r, adp_stat_r, 4'h0};
    end else if (reg_addr == `PCM_A_WAKE) begin
      reg_rdata = wake_r;
    end else if (reg_addr == `PCM_A_CMPA) begin
      reg_rdata = cmpa_r;
    end else if (reg_addr == `PCM_A_CMPB) begin
      reg_rdata = cmpb_r;
    end else if (reg_addr == `PCM_A_CMPC) begin
      reg_rdata = cmpc_r;
    end
  end

  // slow tick divider, one pulse each slow period
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= 13'h0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_CYC[12:0] - 13'h0001) begin
      tick_cnt_r <= 13'h0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 13'h0001;
      tick_r     <= 1'b0;
    end
  end

  // table lookups for debounce and pulse lengths
  always @* begin
    case (adp_r[3:2])
      2'b00:   adp_lim = `PCM_ADP_81US;
      2'b01:   adp_lim = `PCM_ADP_10MS;
      2'b10:   adp_lim = `PCM_ADP_20MS;
      default: adp_lim = `PCM_ADP_30MS;
    endcase
    case (lbat_r[7:6])
      2'b00:   bat_lim = 8'd4;
      2'b01:   bat_lim = 8'd32;
      2'b10:   bat_lim = 8'd64;
      default: bat_lim = 8'd128;
    endcase
    case (rst_r[4:3])
      2'b00:   rst_lim = `PCM_RST_20MS;
      2'b01:   rst_lim = `PCM_RST_40MS;
      2'b10:   rst_lim = `PCM_RST_80MS;
      default: rst_lim = `PCM_RST_200MS;
    endcase
    case (vlim_r[5:4])
      2'b00:   il_lim = 12'd0;
      2'b01:   il_lim = `PCM_US10_CYC;
      2'b10:   il_lim = TICK_CYC[11:0];
      default: il_lim = {TICK_CYC[10:0], 1'b0};
    endcase
  end

  // adapter debounce in slow ticks; only edges allowed by mode update status
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adp_raw_r  <= 1'b0;
      adp_cnt_r  <= 10'h000;
      adp_stat_r <= 1'b0;
    end else begin
      adp_raw_r <= adapter_in & lbat_r[`PCM_B_ACEN];
      if (adp_raw_r == adp_stat_r) begin
        adp_cnt_r <= 10'h000;
      end else if (tick_r) begin
        if (adp_cnt_r + 10'h001 >= adp_lim) begin
          adp_cnt_r <= 10'h000;
          if ((adp_raw_r & adp_r[0]) | (~adp_raw_r & adp_r[1])) begin
            adp_stat_r <= adp_raw_r;
          end
        end else begin
          adp_cnt_r <= adp_cnt_r + 10'h001;
        end
      end
    end
  end

  // battery low filters, status held low while a detector is disabled
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      b1_cnt_r  <= 8'h00;
      b2_cnt_r  <= 8'h00;
      b1_stat_r <= 1'b0;
      b2_stat_r <= 1'b0;
    end else begin
      if (!lbat_r[`PCM_B_BAT1EN] || (batt1_low_in == b1_stat_r)) begin
        b1_cnt_r <= 8'h00;
        if (!lbat_r[`PCM_B_BAT1EN]) b1_stat_r <= 1'b0;
      end else if (tick_r) begin
        if (b1_cnt_r + 8'h01 >= bat_lim) begin
          b1_cnt_r  <= 8'h00;
          b1_stat_r <= batt1_low_in;
        end else begin
          b1_cnt_r <= b1_cnt_r + 8'h01;
        end
      end
      if (!lbat_r[`PCM_B_BAT2EN] || (batt2_low_in == b2_stat_r)) begin
        b2_cnt_r <= 8'h00;
        if (!lbat_r[`PCM_B_BAT2EN]) b2_stat_r <= 1'b0;
      end else if (tick_r) begin
        if (b2_cnt_r + 8'h01 >= bat_lim) begin
          b2_cnt_r  <= 8'h00;
          b2_stat_r <= batt2_low_in;
        end else begin
          b2_cnt_r <= b2_cnt_r + 8'h01;
        end
      end
    end
  end

  // input undervoltage deglitch counted in clock cycles
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      il_cnt_r      <= 12'h000;
      input_low_det <= 1'b0;
    end else if (!vlim_r[`PCM_B_VLCMP] || (vlim_r[3:0] == 4'h0) || vlim_r[3]) begin
      il_cnt_r      <= 12'h000;
      input_low_det <= 1'b0;
    end else if (!input_sense_low) begin
      il_cnt_r      <= 12'h000;
      input_low_det <= 1'b0;
    end else if (il_cnt_r >= il_lim) begin
      input_low_det <= 1'b1;
    end else begin
      il_cnt_r <= il_cnt_r + 12'h001;
    end
  end

  // reset pulse: trip edge or forced request starts a low pulse of the length selected by rst_r[4:3]
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trip_d_r        <= 1'b0;
      emergency_reset <= 1'b0;
      rst_cnt_r       <= 13'h0000;
      reset_n_out     <= 1'b1;
    end else begin
      trip_d_r        <= voltage_trip;
      emergency_reset <= reg_wr & (reg_addr == `PCM_A_FORCED_EMERGENCY_RESET) & reg_wdata[`PCM_B_FORCED_EMERGENCY_RESET];
      if (emergency_reset | (voltage_trip & ~trip_d_r)) begin
        rst_cnt_r   <= rst_lim;
        reset_n_out <= 1'b0;
      end else if (rst_cnt_r != 13'h0000) begin
        if (tick_r) rst_cnt_r <= rst_cnt_r - 13'h0001;
      end else begin
        reset_n_out <= 1'b1;
      end
    end
  end

  // 1 Hz wake clock from slow ticks, held low while disabled
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_cnt_r <= 15'h0000;
      wake_clk   <= 1'b0;
    end else if (!wake_r[`PCM_B_WAKE]) begin
      wake_cnt_r <= 15'h0000;
      wake_clk   <= 1'b0;
    end else if (tick_r) begin
      if (wake_cnt_r == `PCM_WAKE_HALF - 15'h0001) begin
        wake_cnt_r <= 15'h0000;
        wake_clk   <= ~wake_clk;
      end else begin
        wake_cnt_r <= wake_cnt_r + 15'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/pcm_regs_asserts.sv */
// concurrent checks on the register bank ports
`timescale 1ns/100ps
`default_nettype none
module pcm_asserts (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_ack,
  input wire logic [7:0] vr_en_pin,
  input wire logic [7:0] vr_enable,
  input wire logic       emergency_reset,
  input wire logic       reset_n_out,
  input wire logic [7:0] comparator_a_reference
);
  logic [7:0] mask_r;
  wire        sd_wr = reg_wr && reg_addr == 8'h49 && reg_wdata[0];
  wire        ca_wr = reg_wr && reg_addr == 8'hDD;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // shadow of the pin mask, so rails left to their pins can be checked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mask_r <= 8'h00;
    else if (reg_wr && reg_addr == 8'h43) mask_r <= reg_wdata;
  end
  ack_follows_a: assert property (reg_ack == (reg_wr | reg_rd)) else $error("ack not tied to strobes");
  pin_pass_a: assert property ((vr_enable & ~mask_r) == (vr_en_pin & ~mask_r)) else $error("unmasked rail off pin");
  forced_emergency_reset_pulse_a: assert property (sd_wr |=> emergency_reset ##1 !emergency_reset) else $error("no one-cycle pulse");
  forced_emergency_reset_cause_a: assert property (emergency_reset |-> $past(sd_wr)) else $error("pulse without write of one");
  rst_low_a: assert property ($rose(emergency_reset) |=> !reset_n_out [*8]) else $error("reset pulse too short");
  forced_emergency_reset_read_a: assert property (reg_addr == 8'h49 |-> reg_rdata == 8'h00) else $error("self-clearing bit reads set");
  stat_rsv_a: assert property (reg_addr == 8'h6F |-> (reg_rdata & 8'h8F) == 8'h00) else $error("status reserved set");
  rst_rsv_a: assert property (reg_addr == 8'h48 |-> reg_rdata[7:5] == 3'h0) else $error("reset ctl reserved set");
  lock_rsv_a: assert property (reg_addr == 8'h42 |-> reg_rdata[7:1] == 7'h00) else $error("lock reserved set");
  cmp_hold_a: assert property (!ca_wr |=> $stable(comparator_a_reference)) else $error("comparator ref moved");
  cmp_load_a: assert property (ca_wr |=> comparator_a_reference == $past(reg_wdata)) else $error("ref not loaded");
endmodule
bind pcm_regs pcm_asserts chk_u (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .vr_en_pin(vr_en_pin), .vr_enable(vr_enable),
  .emergency_reset(emergency_reset), .reset_n_out(reset_n_out), .comparator_a_reference(comparator_a_reference));
`default_nettype wire

/* File: test/pcm_host.sv */
// bus master model standing in for the embedded controller
`timescale 1ns/100ps
`default_nettype none
module pcm_host (
  input  wire logic       clk,
  input  wire logic       reg_ack,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 8'h00;
  end
  // one access: raise after an edge, hold until ack is sampled, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reg_ack !== 1'b1 && n < 8);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // released lines show the inverse so a stale value cannot pass for a match
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int TC = 2;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       reg_wr, reg_rd, reg_ack, reset_n_out, emergency_reset, wake_clk, input_low_det;
  logic       input_sense_low, adapter_in, batt1_low_in, batt2_low_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, vr_en_pin, vr_enable, d;
  logic [7:0] exp_q[$];
  int         compares = 0;
  int         miscompares = 0;
  int         n;
  logic [7:0] ra[12] = '{8'h42, 8'h43, 8'h48, 8'h49, 8'h51, 8'h69, 8'h6A, 8'h6F, 8'hD0, 8'hDD, 8'hDE, 8'hDF};
  logic [7:0] rv[12] = '{8'h00, 8'h00, 8'h1C, 8'h00, 8'h05, 8'h0F, 8'hF8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] rm[12] = '{8'h01, 8'hFF, 8'h1F, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  always #2 clk = ~clk;
  pcm_host host_u (.clk(clk), .reg_ack(reg_ack), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  pcm_regs #(.TICK_CYC(TC)) dut_u (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .vr_en_pin(vr_en_pin), .vr_enable(vr_enable),
    .input_sense_low(input_sense_low), .adapter_in(adapter_in), .batt1_low_in(batt1_low_in),
    .batt2_low_in(batt2_low_in), .voltage_trip(1'b0), .input_low_det(input_low_det), .reset_n_out(reset_n_out),
    .emergency_reset(emergency_reset), .wake_clk(wake_clk), .reset_trip_level(), .input_low_threshold(),
    .input_low_comparator_enable(), .adapter_comparator_enable(), .battery_one_detect_enable(),
    .battery_two_detect_enable(), .comparator_a_reference(), .comparator_b_reference(), .comparator_c_reference());
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_u.xfer(1'b1, a, v);
  endtask
  // the expected byte is noted before the read goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, a, 8'h00);
  endtask
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // read monitor: each sampled read takes the oldest note off the queue
  always @(posedge clk) begin
    if (rstn && reg_rd === 1'b1) begin
      if (exp_q.size() == 0) chk8("read_queue", 8'h00, 8'hFF);
      else chk8("read_data", exp_q.pop_front(), reg_rdata);
    end
  end
  // watchdog, sized well past the wake clock half period and past the worst-case cycle budget of all wait limits
  initial begin
    #(60000 * 4);
    miscompares++;
    print_verdict();
  end
  initial begin
    {input_sense_low, adapter_in, batt1_low_in, batt2_low_in} = 4'h0;
    vr_en_pin = 8'h00;
    d = $urandom(2431);
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    chk8("wake_off", 8'h00, {7'h0, wake_clk});
    for (int i = 0; i < 12; i++) rd(ra[i], rv[i]);
    rd(8'h00, 8'h00);
    // random bytes into every register but the regulator control, bit 0 of the reset trigger kept clear
    for (int i = 0; i < 12; i++) begin
      d = $urandom & ((ra[i] == 8'h49) ? 8'hFE : 8'hFF);
      wr(ra[i], d);
      rd(ra[i], d & rm[i]);
    end
    wr(8'h42, 8'h00);
    wr(8'h43, 8'hFF);
    wr(8'h44, 8'hA5);
    @(posedge clk);
    chk8("vr_enable", 8'hA5, vr_enable);
    wr(8'h42, 8'h01);
    wr(8'h44, 8'h5A);
    @(posedge clk);
    chk8("vr_locked", 8'hA5, vr_enable);
    wr(8'h42, 8'h00);
    wr(8'h44, 8'h3C);
    wr(8'h43, 8'h0F);
    d = $urandom;
    vr_en_pin <= d;
    @(posedge clk);
    chk8("vr_mixed", {d[7:4], 4'hC}, vr_enable);
    wr(8'h48, 8'h04);
    wr(8'h49, 8'h01);
    n = 0;
    while (reset_n_out !== 1'b0 && n < 10) begin @(posedge clk); n++; end
    n = 0;
    while (reset_n_out !== 1'b1 && n < 20000) begin @(posedge clk); n++; end
    chk8("rst_len", 8'h01, {7'h0, n >= 655 * TC && n <= 657 * TC});
    wr(8'h6A, 8'h38);
    wr(8'h69, 8'h03);
    {batt2_low_in, batt1_low_in, adapter_in} <= 3'b111;
    rd(8'h6F, 8'h00);
    repeat (60) @(posedge clk);
    rd(8'h6F, 8'h70);
    wr(8'h6A, 8'h00);
    repeat (60) @(posedge clk);
    rd(8'h6F, 8'h00);
    input_sense_low <= 1'b1;
    wr(8'h51, 8'h41);
    repeat (20) @(posedge clk);
    chk8("in_low", 8'h01, {7'h0, input_low_det});
    wr(8'h51, 8'h01);
    repeat (20) @(posedge clk);
    chk8("in_low_off", 8'h00, {7'h0, input_low_det});
    wr(8'h51, 8'h51);
    repeat (2000) @(posedge clk);
    chk8("in_low_early", 8'h00, {7'h0, input_low_det});
    repeat (1000) @(posedge clk);
    chk8("in_low_late", 8'h01, {7'h0, input_low_det});
    wr(8'h51, 8'h40);
    repeat (20) @(posedge clk);
    chk8("in_low_nolim", 8'h00, {7'h0, input_low_det});
    // threshold codes 1xxx are not applicable and must keep detection off
    wr(8'h51, 8'h48);
    repeat (20) @(posedge clk);
    chk8("in_low_na", 8'h00, {7'h0, input_low_det});
    wr(8'hD0, 8'h00);
    wr(8'hD0, 8'h01);
    n = 0;
    while (wake_clk !== 1'b1 && n < 34000) begin @(posedge clk); n++; end
    chk8("wake_on", 8'h01, {7'h0, wake_clk});
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule
`default_nettype wire
